// ### i2c_port_boost_mode_control_tb.sv
// Purpose: end-to-end bench for the host and device pair
// Assumes: host runs the link at 500 kHz, so each transfer costs several thousand cycles
// Notes:   fault inputs are one-bit levels gathered in flt
`timescale 1ns/100ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_errors++; \
    $display("Error t=%0t got %h exp %h", $time, a, b); end end
module i2c_port_boost_mode_control_tb;
    logic        pclk, presetn, psel, penable, pwrite, pin, cd, e, uv, bi;
    logic        pready, pslverr, boost_active, high_impedance, force_pwm_en;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, r;
    logic [4:0]  flt;
    int          checks, n_errors;
    wire  [1:0]  mo = {high_impedance, boost_active};

    ibm_i2c_if bus();
    ibm_dev #(.STAT_CYC(20)) i_ibm_dev (.pclk(pclk), .presetn(presetn), .bus(bus),
        .boost_request_pin(pin), .charge_disable_pin(cd), .vbus_over_6v(flt[0]),
        .softstart_fail(flt[1]), .current_limit(flt[2]), .die_overheat(flt[3]),
        .battery_low(flt[4]), .input_undervoltage(uv), .battery_inserted(bi),
        .boost_active(boost_active), .high_impedance(high_impedance),
        .force_pwm_en(force_pwm_en));
    ibm_host i_ibm_host (.pclk(pclk), .presetn(presetn), .bus(bus), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));
    ibm_asserts #(.STAT_CYC(20)) i_ibm_asserts (.pclk(pclk), .presetn(presetn),
        .scl(bus.scl), .sda(bus.sda), .dev_sda_oe_n(bus.dev_sda_oe_n),
        .dev_stat_oe_n(bus.dev_stat_oe_n));

    task summarize;
        $display("checks %0d errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // busy is polled rather than timed: the link length is the host's business
    task xfer(input logic rd, input logic [7:0] rg, input logic [7:0] wd, input logic [7:0] x);
        apb(1'b1, 8'h00, {8'h00, wd, rg, 6'h00, rd, 1'b1});
        do apb(1'b0, 8'h04, 32'h0); while (r[0] !== 1'b0);
        `CHK(r[1], 1'b0);
        if (rd) `CHK(r[15:8], x);
    endtask

    task await(input int k, input logic v);
        for (int n = 0; n < 3000 && mo[k] !== v; n++) @(posedge pclk);
        `CHK(mo[k], v);
    endtask

    task t_fpwm;
        `CHK(force_pwm_en, 1'b0);
        `CHK(boost_active, 1'b0);
        xfer(1'b1, 8'h02, 8'h00, 8'h02);
        xfer(1'b0, 8'h0a, 8'h08, 8'h00);
        `CHK(force_pwm_en, 1'b1);
    endtask

    task t_ovp;
        xfer(1'b0, 8'h01, 8'h01, 8'h00);
        await(0, 1'b1);
        flt <= 5'h01;
        await(0, 1'b0);
        flt <= 5'h00;
        repeat (50) @(posedge pclk);
        `CHK(boost_active, 1'b0);
        xfer(1'b1, 8'h09, 8'h00, 8'h01);
    endtask

    task t_pin;
        xfer(1'b0, 8'h02, 8'h01, 8'h00);
        pin <= 1'b0;
        await(0, 1'b1);
        for (int j = 1; j < 5; j++) begin
            flt <= 5'h01 << j;
            await(0, 1'b0);
            flt <= 5'h00;
            await(0, 1'b1);
            // let the indicator pulse end before the next fault
            repeat (40) @(posedge pclk);
        end
        xfer(1'b1, 8'h09, 8'h00, 8'h03);
        pin <= 1'b1;
        await(0, 1'b0);
    endtask

    task t_hz;
        cd <= 1'b1;
        await(1, 1'b1);
        cd <= 1'b0;
        repeat (50) @(posedge pclk);
        `CHK(high_impedance, 1'b1);
        uv <= 1'b1;
        xfer(1'b0, 8'h01, 8'h00, 8'h00);
        `CHK(high_impedance, 1'b1);
        uv <= 1'b0;
        await(1, 1'b0);
        bi <= 1'b1;
        await(1, 1'b1);
        apb(1'b0, 8'h08, 32'h0);
        `CHK(e, 1'b1);
        `CHK(r, 32'h0);
    endtask

    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    initial begin
        #800000;
        n_errors++;
        summarize();
    end

    initial begin
        {presetn, psel, penable, pwrite, cd, uv, bi, flt, paddr, pwdata} = '0;
        pin = 1'b1;
        checks = 0;
        n_errors = 0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
        t_fpwm();
        t_ovp();
        t_pin();
        t_hz();
        summarize();
    end
endmodule // i2c_port_boost_mode_control_tb

// ### ibm_asserts.sv
// Purpose: wire-level checks of the two-wire link between host and device
// Assumes: host moves scl and sda only from pclk flops
// Notes:   sees interface signals only; byte position is tracked from the wires
`timescale 1ns/100ps
module ibm_asserts #(
    parameter int STAT_CYC = 20
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic scl,
    input wire logic sda,
    input wire logic dev_sda_oe_n,
    input wire logic dev_stat_oe_n
);
    logic        scl_q, sda_q, first;
    logic [3:0]  cnt;
    logic [7:0]  sh;
    logic [15:0] run;
    wire         start = scl && scl_q && sda_q && !sda;

    // first flags the address byte after any start, repeated ones included
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {scl_q, sda_q} <= 2'h3;
            {first, cnt, sh, run} <= '0;
        end else begin
            scl_q <= scl;
            sda_q <= sda;
            run <= dev_stat_oe_n ? 16'h0 : run + 16'h1;
            if (start) begin
                cnt <= 4'h0;
                first <= 1'b1;
            end else if (scl && !scl_q) begin
                cnt <= cnt + 4'h1;
                sh <= {sh[6:0], sda};
            end else if (!scl && scl_q && cnt == 4'h9) begin
                cnt <= 4'h0;
                first <= 1'b0;
            end
        end
    end

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_stat_max: assert property (run <= STAT_CYC)
        else $error("indicator held low too long");
    a_stat_full: assert property ($rose(dev_stat_oe_n) |-> run == STAT_CYC)
        else $error("indicator pulse cut short");
    a_stat_start: assert property ($fell(dev_stat_oe_n) |=> !dev_stat_oe_n [*8])
        else $error("indicator glitch");
    a_sda_lowscl: assert property ($changed(dev_sda_oe_n) |-> !scl)
        else $error("device moved data while clock high");
    a_scl_stable: assert property ($rose(scl) |-> $stable(dev_sda_oe_n) [*8])
        else $error("device data unstable in high phase");
    a_addr_quiet: assert property ($rose(scl) && first && cnt < 4'h8 |-> dev_sda_oe_n)
        else $error("device drove address bits");
    a_addr_ack: assert property ($rose(scl) && first && cnt == 4'h8 |->
        !dev_sda_oe_n == (sh[7:1] == 7'h6a))
        else $error("address ack wrong");
    a_ack_hold: assert property ($rose(scl) && cnt == 4'h8 && !dev_sda_oe_n |=>
        !dev_sda_oe_n [*8])
        else $error("ack released early");
endmodule // ibm_asserts

// ### ibm_dev.sv
// Purpose: device end: two-wire register port and boost / high-impedance mode control
// Assumes: every pin and comparator input is asynchronous to pclk
// Notes:   comparator hysteresis lives in the analogue; this logic follows the levels
// Operation
// - register bit enables forced fixed-frequency, reset off
// - one 128 us low indicator pulse per fault
// - fault clears register boost request, leave boost
// - fault type code written to fault field
// - bus overvoltage above 6 V is fault
// - soft-start fail or limit over 20 us
// - die overheat suspends boost until it clears; code clears register request as for any fault, so only pin boost resumes
// - battery low stops the converter
// - register boost needs new write after fault
// - polarity bit picks active pin level; pin restarts
// - two ways to enable boost
// - four causes enter high-impedance mode
// - leave high impedance only when all clear
// - target address 1101010, then direction bit
// - start or stop mid-transaction aborts it
// - bytes are 8 bits, msb first, acknowledged
// - device pulls data low in ninth clock
// - write: address, register, data, auto-increment
// - read after register write and restart
// - host ack: increment and send next register
// - host nack: release data, wait for stop
// - boost request bit 0, high-z bit 1, reset 0
`timescale 1ns/100ps
`include "ibm_map.svh"
module ibm_dev
    import ibm_pkg::*;
#(
    parameter int STAT_CYC = `IBM_STAT_PULSE_US * `IBM_CLK_MHZ
) (
    input  wire logic pclk,
    input  wire logic presetn,
    ibm_i2c_if.dev    bus,
    input  wire logic boost_request_pin,
    input  wire logic charge_disable_pin,
    input  wire logic vbus_over_6v,
    input  wire logic softstart_fail,
    input  wire logic current_limit,
    input  wire logic die_overheat,
    input  wire logic battery_low,
    input  wire logic input_undervoltage,
    input  wire logic battery_inserted,
    output logic      boost_active,
    output logic      high_impedance,
    output logic      force_pwm_en
);
    import ibm_pkg::*;

    localparam logic [11:0] ILIM_CYC = 12'(`IBM_ILIM_US * `IBM_CLK_MHZ);
    localparam logic [15:0] STAT_LD  = 16'(STAT_CYC);

    ibm_dev_t r, n;

    function automatic logic [7:0] rd_reg(input ibm_dev_t s, input logic [7:0] a);
        logic [7:0] d;
        d = 8'h00;
        case (a)
            `IBM_REG_STATUS: begin
                d[`IBM_B_PINST] = s.s2[`IBM_IN_PIN];
                d[`IBM_B_BOOST] = s.boosting;
            end
            `IBM_REG_CTRL: begin
                d[`IBM_B_BREQ]  = s.breq;
                d[`IBM_B_HZREQ] = s.hzreq;
            end
            `IBM_REG_PIN: begin
                d[`IBM_B_PINEN] = s.pin_en;
                d[`IBM_B_POL]   = s.pol;
            end
            `IBM_REG_FAULT: d[2:0] = s.fcode;
            `IBM_REG_FPWM:  d[`IBM_B_FPWM] = s.fpwm;
            default:        d = 8'h00;
        endcase
        return d;
    endfunction

    logic scl, sda, rise, fall, start, stop;
    logic pin_act, en_req, c_ovp, c_ovl, c_blow, c_hot, any_c, flt_evt, hz_set;

    always_comb begin
        n = r;
        n.s1 = {battery_inserted, input_undervoltage, battery_low, die_overheat,
                current_limit, softstart_fail, vbus_over_6v, charge_disable_pin,
                boost_request_pin, bus.sda, bus.scl};
        n.s2 = r.s1;
        scl = r.s2[`IBM_IN_SCL];
        sda = r.s2[`IBM_IN_SDA];
        n.scl_d  = scl;
        n.sda_d  = sda;
        n.bins_d = r.s2[`IBM_IN_BINS];
        rise  = scl & ~r.scl_d;
        fall  = ~scl & r.scl_d;
        start = scl & r.scl_d & r.sda_d & ~sda;
        stop  = scl & r.scl_d & ~r.sda_d & sda;
        if (rise) begin
            n.cnt = r.cnt + 4'h1;
        end

        // serial port
        if (start) begin
            n.st = D_ADDR;
            n.cnt = 4'h0;
            n.sda_oe_n = 1'b1;
        end else if (stop) begin
            n.st = D_IDLE;
            n.sda_oe_n = 1'b1;
        end else begin
            case (r.st)
                D_IDLE, D_IGN: n.st = r.st;
                D_ADDR, D_REG, D_WDAT: begin
                    if (rise) begin
                        n.sh = {r.sh[6:0], sda};
                    end
                    if (fall && r.cnt == 4'h8) begin
                        n.cnt = 4'h0;
                        n.sda_oe_n = 1'b0;
                        if (r.st == D_ADDR) begin
                            n.rw = r.sh[0];
                            n.st = D_AACK;
                            if (r.sh[7:1] != `IBM_TGT_ADDR) begin
                                n.sda_oe_n = 1'b1;
                                n.st = D_IGN;
                            end
                        end else if (r.st == D_REG) begin
                            n.ptr = r.sh;
                            n.st = D_RACK;
                        end else begin
                            n.st = D_WACK;
                            case (r.ptr)
                                `IBM_REG_CTRL: begin
                                    n.breq  = r.sh[`IBM_B_BREQ];
                                    n.hzreq = r.sh[`IBM_B_HZREQ];
                                    if (!r.sh[`IBM_B_HZREQ]) begin
                                        n.hz_zero = 1'b1;
                                    end
                                end
                                `IBM_REG_PIN: begin
                                    n.pin_en = r.sh[`IBM_B_PINEN];
                                    n.pol    = r.sh[`IBM_B_POL];
                                end
                                `IBM_REG_FPWM: n.fpwm = r.sh[`IBM_B_FPWM];
                                default: n.fpwm = r.fpwm;
                            endcase
                        end
                    end
                end
                D_AACK, D_RACK, D_WACK: begin
                    if (fall) begin
                        n.cnt = 4'h0;
                        n.sda_oe_n = 1'b1;
                        if (r.st == D_AACK && r.rw == `IBM_RD_BIT) begin
                            n.sh = rd_reg(r, r.ptr);
                            n.sda_oe_n = n.sh[7];
                            n.st = D_RDAT;
                        end else if (r.st == D_AACK) begin
                            n.st = D_REG;
                        end else begin
                            n.st = D_WDAT;
                            if (r.st == D_WACK) begin
                                n.ptr = r.ptr + 8'h01;
                            end
                        end
                    end
                end
                D_RDAT: begin
                    if (fall) begin
                        if (r.cnt == 4'h8) begin
                            n.sda_oe_n = 1'b1;
                            n.st = D_HACK;
                        end else begin
                            n.sh = {r.sh[6:0], 1'b0};
                            n.sda_oe_n = n.sh[7];
                        end
                    end
                end
                D_HACK: begin
                    if (rise && sda) begin
                        n.st = D_IGN;
                    end else if (fall) begin
                        n.cnt = 4'h0;
                        n.ptr = r.ptr + 8'h01;
                        n.sh = rd_reg(r, n.ptr);
                        n.sda_oe_n = n.sh[7];
                        n.st = D_RDAT;
                    end
                end
                default: n.st = D_IDLE;
            endcase
        end

        // boost control
        pin_act = r.pin_en && (r.s2[`IBM_IN_PIN] == r.pol);
        en_req = pin_act || (n.breq && !n.hzreq);
        if (r.boosting && r.s2[`IBM_IN_ILIM]) begin
            if (r.ilim_cnt <= ILIM_CYC) begin
                n.ilim_cnt = r.ilim_cnt + 12'h001;
            end
        end else begin
            n.ilim_cnt = 12'h000;
        end
        c_ovp  = r.s2[`IBM_IN_OVP];
        c_ovl  = r.s2[`IBM_IN_SSF] || (r.ilim_cnt > ILIM_CYC);
        c_hot  = r.s2[`IBM_IN_HOT];
        c_blow = r.s2[`IBM_IN_BLOW];
        any_c  = c_ovp | c_ovl | c_hot | c_blow;
        flt_evt = r.boosting && any_c;
        // pin-driven boost comes back once every condition clears
        n.boosting = en_req && !any_c;
        if (flt_evt) begin
            n.breq = 1'b0;
            n.boosting = 1'b0;
            n.stat_cnt = STAT_LD;
            if (c_ovp) begin
                n.fcode = `IBM_FLT_OVP;
            end else if (c_ovl) begin
                n.fcode = `IBM_FLT_OVL;
            end else if (c_blow) begin
                n.fcode = `IBM_FLT_BLOW;
            end else begin
                n.fcode = `IBM_FLT_HOT;
            end
        end else if (r.stat_cnt != 16'h0000) begin
            n.stat_cnt = r.stat_cnt - 16'h0001;
        end
        n.stat_oe_n = (n.stat_cnt == 16'h0000);

        // high-impedance mode
        hz_set = r.s2[`IBM_IN_CD] || (n.hzreq && !pin_act) || r.s2[`IBM_IN_INPUT_UNDERVOLTAGE_THRESHOLD]
               || (r.s2[`IBM_IN_BINS] && !r.bins_d && !r.s2[`IBM_IN_INPUT_UNDERVOLTAGE_THRESHOLD]);
        if (hz_set) begin
            n.hz = 1'b1;
            if (!r.hz) begin
                n.hz_zero = 1'b0;
            end
        end else if (r.hz && n.hz_zero && !n.hzreq) begin
            n.hz = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '0;
            r.st <= D_IDLE;
            r.sda_oe_n <= 1'b1;
            r.stat_oe_n <= 1'b1;
            r.pol <= `IBM_RST_POL;
            // idle levels, so no false edge or false high-z entry follows reset
            r.s1 <= `IBM_IN_IDLE;
            r.s2 <= `IBM_IN_IDLE;
            r.scl_d <= 1'b1;
            r.sda_d <= 1'b1;
            r.breq <= 1'b0;
            r.hzreq <= 1'b0;
            r.fpwm <= 1'b0;
        end else begin
            r <= n;
        end
    end

    // open-drain drivers only ever pull low
    assign bus.dev_sda_o     = 1'b0;
    assign bus.dev_stat_o    = 1'b0;
    assign bus.dev_sda_oe_n  = r.sda_oe_n;
    assign bus.dev_stat_oe_n = r.stat_oe_n;
    assign boost_active      = r.boosting;
    assign high_impedance    = r.hz;
    assign force_pwm_en      = r.fpwm;
endmodule // ibm_dev

// ### ibm_host.sv
// Purpose: host end: apb-programmed two-wire controller for single-register access
// Assumes: no clock stretching by the device
// Notes:   a read is register write, repeated start, one byte, nack, stop
`timescale 1ns/100ps
`include "ibm_map.svh"
module ibm_host
    import ibm_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    ibm_i2c_if.host          bus,
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr
);
    import ibm_pkg::*;

    localparam logic [8:0] QTR = 9'(`IBM_CLK_MHZ * 1000 / (4 * `IBM_I2C_KHZ));

    ibm_host_t r, n;
    logic      tk, acc;

    function automatic logic [7:0] tx_byte(input logic rd, input logic [2:0] s,
                                          input logic [7:0] rg, input logic [7:0] wd);
        logic [7:0] b;
        b = 8'hff;
        case (s)
            3'h1:    b = {`IBM_TGT_ADDR, `IBM_WR_BIT};
            3'h2:    b = rg;
            3'h3:    b = rd ? 8'hff : wd;
            3'h4:    b = {`IBM_TGT_ADDR, `IBM_RD_BIT};
            default: b = 8'hff;
        endcase
        return b;
    endfunction

    always_comb begin
        n = r;
        n.s1 = bus.sda;
        n.s2 = r.s1;
        tk = (r.tick == QTR - 9'h001);
        n.tick = (tk || r.st == H_IDLE) ? 9'h000 : r.tick + 9'h001;
        if (tk) begin
            n.q = r.q + 2'h1;
        end
        case (r.st)
            H_IDLE: n.q = 2'h0;
            H_START: begin
                if (tk) begin
                    case (r.q)
                        2'h0: n.sda_oe_n = 1'b1;
                        2'h1: n.scl_oe_n = 1'b1;
                        2'h2: n.sda_oe_n = 1'b0;
                        default: begin
                            n.scl_oe_n = 1'b0;
                            n.step = r.step + 3'h1;
                            n.sh = tx_byte(r.rd, n.step, r.rg, r.wd);
                            n.cnt = 4'h0;
                            n.st = H_BIT;
                        end
                    endcase
                end
            end
            H_BIT: begin
                if (tk) begin
                    case (r.q)
                        // data only moves while the clock is low
                        2'h0: n.sda_oe_n = (r.cnt == 4'h8) ? 1'b1 : r.sh[7];
                        2'h1: n.scl_oe_n = 1'b1;
                        2'h2: n.smp = r.s2;
                        default: begin
                            n.scl_oe_n = 1'b0;
                            n.cnt = r.cnt + 4'h1;
                            if (r.cnt != 4'h8) begin
                                n.sh = {r.sh[6:0], r.smp};
                            end else if (r.smp && r.step != 3'h5) begin
                                n.nack = 1'b1;
                                n.st = H_STOP;
                            end else if (r.step == 3'h5) begin
                                n.rdata = r.sh;
                                n.st = H_STOP;
                            end else if (r.rd && r.step == 3'h2) begin
                                n.st = H_START;
                                // the restart bumps this to the read address byte
                                n.step = 3'h3;
                            end else if (!r.rd && r.step == 3'h3) begin
                                n.st = H_STOP;
                            end else begin
                                n.step = r.step + 3'h1;
                                n.sh = tx_byte(r.rd, n.step, r.rg, r.wd);
                                n.cnt = 4'h0;
                            end
                        end
                    endcase
                end
            end
            default: begin
                if (tk) begin
                    case (r.q)
                        2'h0: n.sda_oe_n = 1'b0;
                        2'h1: n.scl_oe_n = 1'b1;
                        2'h2: n.sda_oe_n = 1'b1;
                        default: begin
                            n.st = H_IDLE;
                            n.busy = 1'b0;
                        end
                    endcase
                end
            end
        endcase

        // apb slave with one wait state; commands while busy are dropped
        acc = psel && penable && !r.pready;
        n.pready = acc;
        n.pslverr = 1'b0;
        if (acc) begin
            n.prdata = 32'h0000_0000;
            if (paddr == `IBM_APB_STAT) begin
                n.prdata[`IBM_S_BUSY] = r.busy;
                n.prdata[`IBM_S_NACK] = r.nack;
                n.prdata[`IBM_S_RD_LSB +: 8] = r.rdata;
            end else if (paddr != `IBM_APB_CMD) begin
                n.pslverr = 1'b1;
            end
            if (pwrite && paddr == `IBM_APB_CMD && !r.busy && pwdata[`IBM_C_GO]) begin
                n.busy = 1'b1;
                n.nack = 1'b0;
                n.rd = pwdata[`IBM_C_READ];
                n.rg = pwdata[`IBM_C_REG_LSB +: 8];
                n.wd = pwdata[`IBM_C_WD_LSB +: 8];
                n.step = 3'h0;
                n.q = 2'h0;
                n.tick = 9'h000;
                n.st = H_START;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '0;
            r.st <= H_IDLE;
            r.scl_oe_n <= 1'b1;
            r.sda_oe_n <= 1'b1;
            r.s1 <= 1'b1;
            r.s2 <= 1'b1;
        end else begin
            r <= n;
        end
    end

    assign bus.host_scl_o    = 1'b0;
    assign bus.host_sda_o    = 1'b0;
    assign bus.host_scl_oe_n = r.scl_oe_n;
    assign bus.host_sda_oe_n = r.sda_oe_n;
    assign prdata            = r.prdata;
    assign pready            = r.pready;
    assign pslverr           = r.pslverr;
endmodule // ibm_host

// ### ibm_i2c_if.sv
// Purpose: two-wire bus plus indicator pin between host and device
// Assumes: every driver is open-drain, low enable means pulling low
// Notes:   the wire levels are resolved here from the enables
`timescale 1ns/100ps
interface ibm_i2c_if;
    logic host_scl_o;
    logic host_scl_oe_n;
    logic host_sda_o;
    logic host_sda_oe_n;
    logic dev_sda_o;
    logic dev_sda_oe_n;
    logic dev_stat_o;
    logic dev_stat_oe_n;
    logic scl;
    logic sda;
    logic stat;

    assign scl  = host_scl_oe_n | host_scl_o;
    assign sda  = (host_sda_oe_n | host_sda_o) & (dev_sda_oe_n | dev_sda_o);
    assign stat = dev_stat_oe_n | dev_stat_o;

    modport dev  (input scl, input sda, output dev_sda_o, output dev_sda_oe_n,
                  output dev_stat_o, output dev_stat_oe_n);
    modport host (input sda, input stat, output host_scl_o, output host_scl_oe_n,
                  output host_sda_o, output host_sda_oe_n);
endinterface // ibm_i2c_if

// ### ibm_map.svh
// Purpose: named offsets, fields, reset values and timing for the boost-port pair
// Assumes: pclk at 125 MHz
// Notes:   included by both ends
`ifndef IBM_MAP_SVH
`define IBM_MAP_SVH
`define IBM_CLK_MHZ        125
`define IBM_STAT_PULSE_US  128
`define IBM_ILIM_US        20
`define IBM_I2C_KHZ        500
`define IBM_TGT_ADDR       7'h6a
`define IBM_RD_BIT         1'b1
`define IBM_WR_BIT         1'b0
// device register offsets
`define IBM_REG_STATUS     8'h00
`define IBM_REG_CTRL       8'h01
`define IBM_REG_PIN        8'h02
`define IBM_REG_FAULT      8'h09
`define IBM_REG_FPWM       8'h0a
// device field positions
`define IBM_B_BREQ         0
`define IBM_B_HZREQ        1
`define IBM_B_PINEN        0
`define IBM_B_POL          1
`define IBM_B_FPWM         3
`define IBM_B_BOOST        3
`define IBM_B_PINST        7
`define IBM_RST_POL        1'b1
// fault codes
`define IBM_FLT_OVP        3'h1
`define IBM_FLT_OVL        3'h2
`define IBM_FLT_BLOW       3'h3
`define IBM_FLT_HOT        3'h5
// synchroniser lanes on the device
`define IBM_IN_SCL         0
`define IBM_IN_SDA         1
`define IBM_IN_PIN         2
`define IBM_IN_CD          3
`define IBM_IN_OVP         4
`define IBM_IN_SSF         5
`define IBM_IN_ILIM        6
`define IBM_IN_HOT         7
`define IBM_IN_BLOW        8
`define IBM_IN_INPUT_UNDERVOLTAGE_THRESHOLD        9
`define IBM_IN_BINS        10
`define IBM_IN_W           11
// only the two bus lanes idle high
`define IBM_IN_IDLE        11'h003
// host apb registers
`define IBM_APB_CMD        8'h00
`define IBM_APB_STAT       8'h04
`define IBM_C_GO           0
`define IBM_C_READ         1
`define IBM_C_REG_LSB      8
`define IBM_C_WD_LSB       16
`define IBM_S_BUSY         0
`define IBM_S_NACK         1
`define IBM_S_RD_LSB       8
`endif

// ### ibm_pkg.sv
// Purpose: types shared by both ends
// Assumes: ibm_map.svh defines the lane width
// Notes:   one packed struct holds all state of each end
`include "ibm_map.svh"
package ibm_pkg;
    typedef enum logic [3:0] {
        D_IDLE = 4'h0, D_ADDR = 4'h1, D_AACK = 4'h2, D_REG = 4'h3, D_RACK = 4'h4,
        D_WDAT = 4'h5, D_WACK = 4'h6, D_RDAT = 4'h7, D_HACK = 4'h8, D_IGN = 4'h9
    } ibm_dst_t;

    typedef enum logic [1:0] {
        H_IDLE = 2'h0, H_START = 2'h1, H_BIT = 2'h2, H_STOP = 2'h3
    } ibm_hst_t;

    typedef struct packed {
        logic [`IBM_IN_W-1:0] s1;
        logic [`IBM_IN_W-1:0] s2;
        logic                 scl_d;
        logic                 sda_d;
        logic                 bins_d;
        ibm_dst_t             st;
        logic [3:0]           cnt;
        logic [7:0]           sh;
        logic [7:0]           ptr;
        logic                 rw;
        logic                 sda_oe_n;
        logic                 breq;
        logic                 hzreq;
        logic                 pin_en;
        logic                 pol;
        logic                 fpwm;
        logic [2:0]           fcode;
        logic                 boosting;
        logic                 hz;
        logic                 hz_zero;
        logic [15:0]          stat_cnt;
        logic                 stat_oe_n;
        logic [11:0]          ilim_cnt;
    } ibm_dev_t;

    typedef struct packed {
        ibm_hst_t    st;
        logic [1:0]  q;
        logic [8:0]  tick;
        logic [3:0]  cnt;
        logic [2:0]  step;
        logic        rd;
        logic [7:0]  sh;
        logic [7:0]  rg;
        logic [7:0]  wd;
        logic [7:0]  rdata;
        logic        smp;
        logic        nack;
        logic        busy;
        logic        scl_oe_n;
        logic        sda_oe_n;
        logic        s1;
        logic        s2;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } ibm_host_t;
endpackage
